// >>> bench/eq_mode_sva.sv
// Checker of the equalizer mode control, bound to its top module.
// Assumes pin inputs reach the outputs within three clocks.
module eq_mode_sva
#(
   parameter int SYNC_STAGES = 2 // Synchroniser depth.
)
(
   input wire logic clk_i, // Clock.
   input wire logic reset_i, // Reset.
   input wire logic spi_en_i, // Mode pin.
   input wire logic bypass_i, // Bypass pin.
   input wire logic mute_i, // Mute pin.
   input wire logic auto_sleep_i, // Sleep pin.
   input wire logic sig_detect_i, // Signal seen.
   input wire logic serial_in_i, // Data in.
   input wire logic sck_i, // Serial clock.
   input wire logic ss_n_i, // Select.
   input wire logic mosi_i, // Data from master.
   input wire logic miso_o, // Data to master.
   input wire logic miso_oe_n_o, // Drive enable.
   input wire logic serial_out_o, // Data out.
   input wire logic carrier_absent_flag_o, // No signal.
   input wire logic eq_bypass_o, // Bypassed.
   input wire logic out_mute_o, // Muted.
   input wire logic power_down_o // Asleep.
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic awake;
   // Pin mode request that auto sleep leaves alone.
   assign awake = !spi_en_i && (sig_detect_i || !auto_sleep_i);
   ////////////////////////////////////////
   a_flag_no_signal: assert property (!sig_detect_i [*4] |-> carrier_absent_flag_o)
      else $error("carrier flag low without signal");
   a_flag_signal: assert property (sig_detect_i [*4] |-> !carrier_absent_flag_o)
      else $error("carrier flag high with signal");
   a_sleep_wins: assert property ((!spi_en_i && auto_sleep_i && !sig_detect_i) [*4]
      |-> power_down_o && !out_mute_o && !eq_bypass_o) else $error("auto sleep not applied");
   a_stay_awake: assert property (awake [*4] |-> !power_down_o)
      else $error("asleep while awake");
   a_mute_over_bypass: assert property ((awake && mute_i) [*4] |-> out_mute_o && !eq_bypass_o)
      else $error("mute not applied");
   a_bypass_pin: assert property ((awake && bypass_i && !mute_i) [*4] |-> eq_bypass_o)
      else $error("bypass not applied");
   a_normal_pins: assert property ((awake && !bypass_i && !mute_i) [*4]
      |-> !eq_bypass_o && !out_mute_o) else $error("control active without request");
   a_quiet_output: assert property ((out_mute_o || power_down_o) [*2] |-> !serial_out_o)
      else $error("output not zero while muted");
   a_miso_pin_off: assert property (!spi_en_i [*3] |-> miso_oe_n_o)
      else $error("read line driven in pin mode");
   a_miso_idle_off: assert property (ss_n_i |-> miso_oe_n_o)
      else $error("read line driven while deselected");
   c_asleep: cover property (power_down_o);
   c_muted: cover property (out_mute_o);
   c_bypassed: cover property (eq_bypass_o);
   c_reading: cover property (!miso_oe_n_o);
endmodule : eq_mode_sva

bind equalizer_mode_pin_control eq_mode_sva #(.SYNC_STAGES(SYNC_STAGES)) chk (.clk_i(clk_i), .reset_i(reset_i),
   .spi_en_i(spi_en_i), .bypass_i(bypass_i), .mute_i(mute_i), .auto_sleep_i(auto_sleep_i),
   .sig_detect_i(sig_detect_i), .serial_in_i(serial_in_i), .sck_i(sck_i), .ss_n_i(ss_n_i), .mosi_i(mosi_i),
   .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .serial_out_o(serial_out_o),
   .carrier_absent_flag_o(carrier_absent_flag_o), .eq_bypass_o(eq_bypass_o), .out_mute_o(out_mute_o),
   .power_down_o(power_down_o));

// >>> bench/spi_master_model.sv
// Serial port master and board strapping beside the equalizer.
// Assumes frames are only started in register mode.
module spi_master_model
(
   input wire logic pin_mode_i, // Board straps pin mode.
   input wire logic miso_i, // Resolved read line.
   output logic sck_o, // Clock, still outside frames.
   output logic ss_n_o, // Select.
   output logic mosi_o // Data out.
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sel_n;
   // Start idle with the clock parked low.
   initial
   begin
      sel_n = 1'b1;
      sck_o = 1'b0;
      mosi_o = 1'b0;
   end
   assign ss_n_o = pin_mode_i ? 1'b0 : sel_n;
   // n bits first to last, read bits taken on rising edge.
   task automatic xfer(input logic [15:0] word, input int n, output logic [7:0] rd);
      rd = 8'h00;
      sel_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         mosi_o = word[15-i];
         #3 sck_o = 1'b1;
         if (i >= 8) rd = {rd[6:0], miso_i};
         #3 sck_o = 1'b0;
      end
      #3 sel_n = 1'b1;
      mosi_o = ~mosi_o; // Released line shows a changed level.
   endtask : xfer
endmodule : spi_master_model

// >>> bench/tb.sv
// Self-checking bench of the equalizer mode control in both modes.
// Assumes the master model and the bound checker.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, en, byp, mute, asl, sd, sin, miso, oe_n, sout, cd, eqb, mtd, pd;
   wire logic sck, ss_n, mosi, miso_w;
   int num_errors = 0;
   int num_checks = 0;
   logic [7:0] ctrl, rd;
   logic [3:0] v;
   logic sin_q[$];
   // Undriven read line shows a moving pattern.
   assign miso_w = oe_n ? ~mosi : miso;
   equalizer_mode_pin_control DUT (.clk_i(clk), .reset_i(rst), .spi_en_i(en), .bypass_i(byp), .mute_i(mute),
      .auto_sleep_i(asl), .sig_detect_i(sd), .serial_in_i(sin), .sck_i(sck), .ss_n_i(ss_n), .mosi_i(mosi),
      .miso_o(miso), .miso_oe_n_o(oe_n), .serial_out_o(sout), .carrier_absent_flag_o(cd), .eq_bypass_o(eqb),
      .out_mute_o(mtd), .power_down_o(pd));
   spi_master_model master (.pin_mode_i(!en), .miso_i(miso_w), .sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi));
   ////////////////////////////////////////
   // Clock and random serial data.
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(negedge clk) sin <= 1'($urandom);
   // Data path model: serial input seen at each rising edge, oldest first, three deep.
   always @(posedge clk)
   begin
      sin_q.push_back(sin);
      if (sin_q.size() > 3)
         void'(sin_q.pop_front());
   end
   // Expected {bypassed, muted, asleep, no carrier}.
   function automatic logic [3:0] expect_out(logic [3:0] c, logic s);
      logic p;
      p = c[3] | (c[2] & !s);
      return {!p & !c[1] & c[0], !p & c[1], p, !s};
   endfunction : expect_out
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic outs(logic [3:0] c);
      logic [3:0] e;
      repeat (8) @(negedge clk);
      e = expect_out(c, sd);
      check({4'h0, eqb, mtd, pd, cd}, {4'h0, e});
      check({7'h00, sout}, {7'h00, (e[2] | e[1]) ? 1'b0 : sin_q[0]});
   endtask : outs
   task automatic frame(logic [15:0] w, int n);
      master.xfer(w, n, rd);
      repeat (10) @(negedge clk);
   endtask : frame
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   // Watchdog against a hang.
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
   // Pin mode, register mode, then pin mode again.
   initial
   begin
      void'($urandom(32'h7fe39954));
      {rst, en, byp, mute, asl, sd, sin} = 7'h48;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 24; i++)
      begin
         v = (i < 16) ? i[3:0] : 4'($urandom);
         {byp, mute, asl, sd} = v;
         outs({1'b0, asl, mute, byp});
      end
      {en, byp, mute, asl, sd} = 5'h1c;
      ctrl = 8'h04;
      outs(ctrl[3:0]);
      for (int i = 0; i < 10; i++)
      begin
         v = (i < 8) ? 4'(i * 5) : 4'($urandom);
         sd = i[0];
         frame({8'h00, 4'h0, v}, 16);
         ctrl = {4'h0, v};
         outs(v);
         frame(16'h8000, 16);
         check(rd, ctrl);
      end
      frame(16'h8100, 16);
      check(rd, {4'h1, expect_out(ctrl[3:0], sd)});
      frame(16'h020f, 16);
      frame(16'h00ff, 12);
      frame(16'h8000, 16);
      check(rd, ctrl);
      frame(16'h8500, 16);
      check(rd, 8'h00);
      en = 1'b0;
      outs({1'b0, asl, mute, byp});
      report_and_stop();
   end
endmodule : tb

// >>> hw/eq_mode_pkg.sv
// Types shared by the equalizer mode control and its serial port receiver.
// Assumes nothing beyond a SystemVerilog compiler.
package eq_mode_pkg;

   // Effective control settings after mode selection.
   typedef struct packed {
      logic force_sleep;
      logic auto_sleep;
      logic mute;
      logic bypass;
   } ctrl_type;

   // One register byte.
   typedef logic [7:0] byte_type;

endpackage : eq_mode_pkg

// >>> hw/eq_mode_regs.svh
// Register offsets, field positions, reset values and frame sizes of the equalizer mode control.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef EQ_MODE_REGS_SVH
`define EQ_MODE_REGS_SVH

// Register addresses within the seven-bit register space.
`define EQ_ADDR_CTRL 7'h00
`define EQ_ADDR_STAT 7'h01

// Control register fields.
`define EQ_CTRL_BYPASS 0
`define EQ_CTRL_MUTE 1
`define EQ_CTRL_AUTO_SLEEP 2
`define EQ_CTRL_FORCE_SLEEP 3
`define EQ_CTRL_RESET 8'h04

// Status register fields.
`define EQ_STAT_CARRIER_ABSENT 0
`define EQ_STAT_ASLEEP 1
`define EQ_STAT_MUTED 2
`define EQ_STAT_BYPASSED 3
`define EQ_STAT_REG_MODE 4

// Frame layout: one command bit, seven address bits, eight data bits.
`define EQ_FRAME_BITS 16
`define EQ_HEAD_BITS 8
`define EQ_CMD_WRITE 1'b0

`endif

// >>> hw/equalizer_mode_pin_control.sv
// Mode and pin control of a serial video cable equalizer: pin mode or register mode.
// Assumes the analog front end reports signal detect as an asynchronous level.
//
// Function
// - Select input high picks register mode.
// - Bypass pin high disables equalization.
// - Mute pin high mutes serial outputs.
// - Mute wins over bypass.
// - Auto sleep wins over mute and bypass.
// - Auto sleep on: power down without signal.
// - Carrier flag high when no signal.
// - Slave select idles high, deselected.
// - Read data on miso, write on mosi.
// - Muted outputs are static zero.
// - Write frame: command, address, data, sixteen bits.
// - Sample on rising edge, miso off during write.
// - Wake automatically once signal returns.
`include "eq_mode_regs.svh"

module equalizer_mode_pin_control
#(
   parameter int SYNC_STAGES = 2     // Flip-flops in each input synchroniser.
)
(
   input wire logic clk_i,           // System clock, 40 MHz.
   input wire logic reset_i,         // Synchronous reset, active high.
   input wire logic spi_en_i,        // Interface select pin, high for register mode.
   input wire logic bypass_i,        // Equalization bypass pin.
   input wire logic mute_i,          // Output mute pin.
   input wire logic auto_sleep_i,    // Auto sleep pin.
   input wire logic sig_detect_i,    // Input signal detected, from the front end.
   input wire logic serial_in_i,     // Equalized serial data.
   input wire logic sck_i,           // Serial port clock.
   input wire logic ss_n_i,          // Serial port slave select, active low.
   input wire logic mosi_i,          // Serial port data in.
   output logic miso_o,              // Serial port data out.
   output logic miso_oe_n_o,         // Low while miso is driven.
   output logic serial_out_o,        // Serial data output.
   output logic carrier_absent_flag_o, // High when no signal is present.
   output logic eq_bypass_o,         // Equalizer disabled.
   output logic out_mute_o,          // Outputs forced to zero.
   output logic power_down_o         // Device in power save.
);

   localparam int SYNC_W = 7;

   spi_link_if link ();

   logic [SYNC_STAGES-1:0] sync_ff [SYNC_W];
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] synced;
   logic reg_mode_ff;
   eq_mode_pkg::byte_type ctrl_ff;
   eq_mode_pkg::byte_type stat_ff;
   eq_mode_pkg::byte_type rd_ctrl_ff;
   eq_mode_pkg::byte_type rd_stat_ff;
   logic ss_high_d_ff;
   eq_mode_pkg::ctrl_type eff;
   logic detect;
   logic ss_high;
   logic asleep;
   logic nxt_mute;
   logic nxt_bypass;
   logic out_mute_ff;
   logic eq_bypass_ff;
   logic power_down_ff;
   logic serial_out_ff;
   logic carrier_absent_ff;

   // Refuse a synchroniser too short to settle.
   if (SYNC_STAGES < 2)
   begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2.");
   end

   // Picks the pin or the register setting according to the mode.
   function automatic logic pick(input logic reg_mode, input logic pin_val, input logic reg_val);
      pick = reg_mode ? reg_val : pin_val;
   endfunction : pick

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers: every pin except clk_i, reset_i, sck_i and mosi_i, the slave select included, passes SYNC_STAGES flip-flops.
   assign raw = {serial_in_i, ss_n_i, sig_detect_i, auto_sleep_i, mute_i, bypass_i, spi_en_i};

   generate
      for (genvar i = 0; i < SYNC_W; i++)
      begin : g_sync
         always_ff @(posedge clk_i)
         begin
            if (reset_i)
               sync_ff[i] <= '0;
            else
               sync_ff[i] <= {sync_ff[i][SYNC_STAGES-2:0], raw[i]};
         end
         assign synced[i] = sync_ff[i][SYNC_STAGES-1];
      end
   endgenerate

   assign detect = synced[4];
   assign ss_high = synced[5];

   ////////////////////////////////////////////////////////////////////////////////
   // Mode selection follows the select level only.
   // select level picks mode
   // level alone switches
   // The last synchroniser stage is the mode register, so mode and pins take the same path length.
   assign reg_mode_ff = synced[0];

   ////////////////////////////////////////////////////////////////////////////////
   // Serial port receiver on its own clock.
   spi_frame_rx u_rx
   (
      .sck_i (sck_i),
      .ss_n_i (ss_n_i),
      .mosi_i (mosi_i),
      .link (link.link)
   );

   // Edge history of the synchronised slave select.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         ss_high_d_ff <= 1'b1;
      else
         ss_high_d_ff <= ss_high;
   end

   // Control register, written at the close of a write frame in register mode.
   // The write results are stable once slave select has risen, so they are read then.
   // frame only while selected
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         ctrl_ff <= `EQ_CTRL_RESET;
      else if (reg_mode_ff && ss_high && !ss_high_d_ff && link.write_ok
               && link.wr_addr == `EQ_ADDR_CTRL)
         ctrl_ff <= link.wr_data;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Effective controls from pins or registers.
   // registers replace pins
   always_comb
   begin
      eff.bypass = pick(reg_mode_ff, synced[1], ctrl_ff[`EQ_CTRL_BYPASS]);
      eff.mute = pick(reg_mode_ff, synced[2], ctrl_ff[`EQ_CTRL_MUTE]);
      eff.auto_sleep = pick(reg_mode_ff, synced[3], ctrl_ff[`EQ_CTRL_AUTO_SLEEP]);
      eff.force_sleep = reg_mode_ff & ctrl_ff[`EQ_CTRL_FORCE_SLEEP];
   end

   // Sleep when auto sleep is on and no signal, waking as soon as it returns.
   // sleep without signal
   assign asleep = eff.force_sleep | (eff.auto_sleep & !detect);

   // Precedence: sleep, then mute, then bypass.
   // sleep overrides all
   always_comb
   begin
      nxt_mute = !asleep && eff.mute;
      nxt_bypass = !asleep && !eff.mute && eff.bypass;
   end

   // Registered control outputs.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         power_down_ff <= 1'b0;
         out_mute_ff <= 1'b0;
         eq_bypass_ff <= 1'b0;
      end
      else
      begin
         power_down_ff <= asleep;
         out_mute_ff <= nxt_mute;
         eq_bypass_ff <= nxt_bypass;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Serial output: static zero while muted or asleep.
   // muted output is zero
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         serial_out_ff <= 1'b0;
      else if (asleep || eff.mute)
         serial_out_ff <= 1'b0;
      else
         serial_out_ff <= synced[6];
   end

   // Carrier flag, active in both modes.
   // flag high without signal
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         carrier_absent_ff <= 1'b1;
      else
         carrier_absent_ff <= !detect;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status byte refreshed every clock; read mirrors refreshed only while no frame is in progress.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         stat_ff <= 8'h00;
      else
      begin
         stat_ff <= 8'h00;
         stat_ff[`EQ_STAT_CARRIER_ABSENT] <= !detect;
         stat_ff[`EQ_STAT_ASLEEP] <= asleep;
         stat_ff[`EQ_STAT_MUTED] <= nxt_mute;
         stat_ff[`EQ_STAT_BYPASSED] <= nxt_bypass;
         stat_ff[`EQ_STAT_REG_MODE] <= reg_mode_ff;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         rd_ctrl_ff <= `EQ_CTRL_RESET;
         rd_stat_ff <= 8'h00;
      end
      else if (ss_high && ss_high_d_ff)
      begin
         rd_ctrl_ff <= ctrl_ff;
         rd_stat_ff <= stat_ff;
      end
   end

   assign link.rd_ctrl = rd_ctrl_ff;
   assign link.rd_stat = rd_stat_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs; the serial port drives miso only in register mode.
   // miso in register mode
   assign miso_o = link.miso;
   assign miso_oe_n_o = !reg_mode_ff || link.miso_oe_n;
   assign serial_out_o = serial_out_ff;
   assign carrier_absent_flag_o = carrier_absent_ff;
   assign eq_bypass_o = eq_bypass_ff;
   assign out_mute_o = out_mute_ff;
   assign power_down_o = power_down_ff;

endmodule : equalizer_mode_pin_control

// >>> hw/spi_frame_rx.sv
// Serial port slave on the serial clock: collects write frames and shifts out read data.
// Assumes the core samples write results only after slave select is seen high again.
`include "eq_mode_regs.svh"

module spi_frame_rx
(
   input wire logic sck_i,      // Serial clock from the master.
   input wire logic ss_n_i,     // Slave select, active low.
   input wire logic mosi_i,     // Command and write data in.
   spi_link_if.link link        // Results toward the core.
);

   logic [4:0] cnt_ff;
   logic [14:0] shift_ff;
   logic is_read_ff;
   logic [6:0] rd_addr;
   eq_mode_pkg::byte_type rd_sh_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Bit counter and shifter, cleared whenever slave select is high.
   // rising edge sampling
   always_ff @(posedge sck_i or posedge ss_n_i)
   begin
      if (ss_n_i)
      begin
         cnt_ff <= 5'h00;
         shift_ff <= 15'h0;
         is_read_ff <= 1'b0;
      end
      else
      begin
         if (cnt_ff != 5'(`EQ_FRAME_BITS))
            cnt_ff <= cnt_ff + 5'h01;
         shift_ff <= {shift_ff[13:0], mosi_i};
         if (cnt_ff == 5'h00)
            is_read_ff <= (mosi_i != `EQ_CMD_WRITE);
      end
   end

   // Write result, held from the sixteenth bit until the next frame starts.
   // sixteen bit write
   always_ff @(posedge sck_i)
   begin
      if (!ss_n_i && cnt_ff == 5'h00)
         link.write_ok <= 1'b0;
      else if (!ss_n_i && cnt_ff == 5'(`EQ_FRAME_BITS - 1) && shift_ff[14] == `EQ_CMD_WRITE)
      begin
         link.write_ok <= 1'b1;
         link.wr_addr <= shift_ff[13:7];
         link.wr_data <= {shift_ff[6:0], mosi_i};
      end
   end

   // Read data goes out on falling edges once the address is in.
   assign rd_addr = shift_ff[6:0];

   always_ff @(negedge sck_i)
   begin
      if (cnt_ff == 5'(`EQ_HEAD_BITS))
         rd_sh_ff <= (rd_addr == `EQ_ADDR_CTRL) ? link.rd_ctrl :
                     (rd_addr == `EQ_ADDR_STAT) ? link.rd_stat : 8'h00;
      else
         rd_sh_ff <= {rd_sh_ff[6:0], 1'b0};
   end

   // Drive from the eighth bit on, so the first data bit already stands at the ninth rising edge.
   // tristate during writes
   assign link.miso_oe_n = !(is_read_ff && cnt_ff >= 5'(`EQ_HEAD_BITS) && !ss_n_i);
   assign link.miso = rd_sh_ff[7];

endmodule : spi_frame_rx

// >>> hw/spi_link_if.sv
// Signals passed between the serial port receiver and the mode control core.
// Assumes the receiver runs on the serial clock and the core on the system clock.
interface spi_link_if;
   logic write_ok;                    // Last frame was a complete write.
   logic [6:0] wr_addr;               // Address of the last write.
   eq_mode_pkg::byte_type wr_data;    // Data of the last write.
   eq_mode_pkg::byte_type rd_ctrl;    // Control byte offered for reading.
   eq_mode_pkg::byte_type rd_stat;    // Status byte offered for reading.
   logic miso;                        // Read data bit.
   logic miso_oe_n;                   // Low while read data is driven.

   modport link (output write_ok, output wr_addr, output wr_data, output miso, output miso_oe_n,
                 input rd_ctrl, input rd_stat);
   modport core (input write_ok, input wr_addr, input wr_data, input miso, input miso_oe_n,
                 output rd_ctrl, output rd_stat);
endinterface : spi_link_if
